// ===== status_regs.sv
// Status word, main operand and second operand registers with interrupt preemption gate.
// Assumes the core drives bus, ALU and interrupt strobes synchronously to core_clk.
`timescale 1ns/10ps
module status_regs #(
   parameter int IRQS = status_regs_pkg::IRQ_SOURCES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Special function register bus.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   output logic [7:0] sfr_rdata,
   // ALU flag updates and operand loads.
   input wire logic alu_flags_we,
   input wire logic carry_in,
   input wire logic half_carry_in,
   input wire logic overflow_in,
   input wire logic main_we,
   input wire logic [7:0] main_wdata,
   input wire logic second_we,
   input wire logic [7:0] second_wdata,
   // Interrupt arbitration.
   input wire logic [IRQS-1:0] irq_pending,
   input wire logic [IRQS-1:0] irq_priority_high,
   input wire logic irq_return,
   output logic irq_take,
   output logic [IRQS-1:0] irq_take_src,
   // Register views.
   output logic [7:0] program_status_word,
   output logic [7:0] main_operand,
   output logic [7:0] second_operand,
   output logic [4:0] bank_base_addr
);
   import status_regs_pkg::*;

   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [7:0] main_q;
   logic [7:0] main_d;
   logic [7:0] second_q;
   logic [7:0] second_d;
   service_level_type level_q;
   service_level_type level_d;
   service_level_type stack_q;
   logic [IRQS-1:0] high_req;
   logic [IRQS-1:0] low_req;
   logic [IRQS-1:0] grant;
   logic take;

   // A byte write wins over a bit write aimed at the same register in one cycle.
   function automatic logic [7:0] bus_update(input logic [7:0] cur,
                                             input logic [7:0] target,
                                             input logic [7:0] addr,
                                             input logic byte_wr,
                                             input logic [7:0] wdata,
                                             input logic bit_wr,
                                             input logic [2:0] bit_sel,
                                             input logic bit_val);
      logic [7:0] upd;
      upd = cur;
      if (addr == target) begin
         if (byte_wr) begin
            upd = wdata;
         end else if (bit_wr) begin
            upd[bit_sel] = bit_val; // RULE12
         end
      end
      return upd;
   endfunction : bus_update

   // Ties inside one priority class go to the lowest source index.
   function automatic logic [IRQS-1:0] lowest_request(input logic [IRQS-1:0] req);
      logic [IRQS-1:0] pick;
      pick = req & (~req + IRQS'(1));
      return pick;
   endfunction : lowest_request

   function automatic logic [4:0] bank_base(input logic [7:0] status);
      logic [4:0] sel;
      sel = {3'h0, status[BANK_UPPER_BIT], status[BANK_LOWER_BIT]};
      return sel << BANK_SHIFT;
   endfunction : bank_base

   always_comb begin
      if (main_we) begin
         main_d = main_wdata; // RULE8
      end else begin
         main_d = bus_update(main_q, MAIN_ADDR, sfr_addr, sfr_wr, sfr_wdata, sfr_bit_wr,
                             sfr_bit_sel, sfr_bit_val); // RULE8
      end
   end

   // Multiply and divide loads take precedence over software writes in the same cycle.
   always_comb begin
      if (second_we) begin
         second_d = second_wdata; // RULE9
      end else begin
         second_d = bus_update(second_q, SECOND_ADDR, sfr_addr, sfr_wr, sfr_wdata, sfr_bit_wr,
                               sfr_bit_sel, sfr_bit_val); // RULE10
      end
   end

   // Parity follows the next operand value so bit 0 is never a cycle stale.
   always_comb begin
      status_d = bus_update(status_q, STATUS_ADDR, sfr_addr, sfr_wr, sfr_wdata, sfr_bit_wr,
                            sfr_bit_sel, sfr_bit_val); // RULE2
      if (alu_flags_we) begin
         status_d[CARRY_BIT] = carry_in; // RULE3
         status_d[HALF_CARRY_BIT] = half_carry_in; // RULE3
         status_d[OVERFLOW_BIT] = overflow_in; // RULE3
      end
      status_d[PARITY_BIT] = ^main_d; // RULE7
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= REG_RESET; // RULE12
      end else begin
         status_q <= status_d; // RULE4
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_q <= REG_RESET; // RULE12
      end else begin
         main_q <= main_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         second_q <= REG_RESET; // RULE12
      end else begin
         second_q <= second_d;
      end
   end

   // Read data shows what the register holds after this edge, a write in it included.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= REG_RESET;
      end else begin
         unique case (sfr_addr)
            STATUS_ADDR: sfr_rdata <= status_d; // RULE2
            MAIN_ADDR: sfr_rdata <= main_d; // RULE8
            SECOND_ADDR: sfr_rdata <= second_d; // RULE9
            default: sfr_rdata <= REG_RESET;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_status_word <= REG_RESET;
      end else begin
         program_status_word <= status_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_operand <= REG_RESET;
      end else begin
         main_operand <= main_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         second_operand <= REG_RESET;
      end else begin
         second_operand <= second_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_base_addr <= BANK_RESET;
      end else begin
         bank_base_addr <= bank_base(status_d); // RULE5 RULE6
      end
   end

   // Two nesting levels exist, so one saved level is all the return path needs.
   always_comb begin
      high_req = irq_pending & irq_priority_high; // RULE11
      low_req = irq_pending & ~irq_priority_high;
      grant = '0;
      take = 1'b0;
      level_d = level_q;
      if (high_req != '0 && level_q != LEVEL_HIGH) begin
         grant = lowest_request(high_req); // RULE1
         take = 1'b1;
         level_d = LEVEL_HIGH;
      end else if (low_req != '0 && level_q == LEVEL_IDLE) begin
         grant = lowest_request(low_req); // RULE1
         take = 1'b1;
         level_d = LEVEL_LOW;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_take <= 1'b0;
      end else begin
         irq_take <= take;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_take_src <= '0;
      end else begin
         irq_take_src <= grant;
      end
   end

   // A take in the same cycle as a return wins; the return is lost.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= LEVEL_IDLE;
      end else if (take) begin
         level_q <= level_d; // RULE1
      end else if (irq_return) begin
         level_q <= stack_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_q <= LEVEL_IDLE;
      end else if (take) begin
         stack_q <= level_q;
      end else if (irq_return) begin
         stack_q <= LEVEL_IDLE;
      end
   end
endmodule : status_regs

// ===== status_regs_pkg.sv
// Constants for the core status word, main operand and second operand registers.
// Assumes a special function register bus with byte address, write strobe and bit strobes.
// Behaviour
// RULE1: In service, only higher priority interrupts preempt.
// RULE2: Status word at D0, all bits read/write; the code overwrites a written bit 0 with parity.
// RULE3: ALU updates carry, half carry, overflow bits.
// RULE4: Bits 5 and 1 are software-only user flags.
// RULE5: Bits 4 and 3 select working bank.
// RULE6: Bank maps registers to 00, 08, 10, 18.
// RULE7: Bit 0 tracks accumulator parity every cycle.
// RULE8: Main operand register at E0, read/write.
// RULE9: Second operand register at F0, read/write.
// RULE10: Second operand register is otherwise scratch storage.
// RULE11: Per-source priority bit selects high level.
// RULE12: Reset clears all three; bit addressable.
package status_regs_pkg;
   localparam logic [7:0] STATUS_ADDR = 8'hD0;
   localparam logic [7:0] MAIN_ADDR = 8'hE0;
   localparam logic [7:0] SECOND_ADDR = 8'hF0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [4:0] BANK_RESET = 5'h00;
   localparam int CARRY_BIT = 7;
   localparam int HALF_CARRY_BIT = 6;
   localparam int USER_HIGH_BIT = 5;
   localparam int BANK_UPPER_BIT = 4;
   localparam int BANK_LOWER_BIT = 3;
   localparam int OVERFLOW_BIT = 2;
   localparam int USER_LOW_BIT = 1;
   localparam int PARITY_BIT = 0;
   localparam int BANK_SHIFT = 3;
   localparam int IRQ_SOURCES = 8;
   typedef enum logic [1:0] {
      LEVEL_IDLE = 2'b00,
      LEVEL_LOW = 2'b01,
      LEVEL_HIGH = 2'b10
   } service_level_type;
endpackage : status_regs_pkg

// ===== status_regs_checker.sv
// Assertions on the status_regs ports.
// Assumes the bind below attaches it to every status_regs instance.
`timescale 1ns/10ps
module status_regs_checker import status_regs_pkg::*; #(
   parameter int IRQS = status_regs_pkg::IRQ_SOURCES
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_bit_wr,
   input wire logic [7:0] sfr_rdata,
   // ALU flag updates and operand loads.
   input wire logic alu_flags_we,
   input wire logic carry_in,
   input wire logic half_carry_in,
   input wire logic overflow_in,
   input wire logic main_we,
   input wire logic [7:0] main_wdata,
   // Interrupt arbitration.
   input wire logic [IRQS-1:0] irq_pending,
   input wire logic irq_take,
   input wire logic [IRQS-1:0] irq_take_src,
   // Register views.
   input wire logic [7:0] program_status_word,
   input wire logic [7:0] main_operand,
   input wire logic [4:0] bank_base_addr
);
   wire logic [7:0] sw = program_status_word;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_par; sw[0] == ^main_operand; endproperty
   a_par: assert property (p_par) else $error("parity");
   property p_bank; bank_base_addr == {sw[4:3], 3'h0}; endproperty
   a_bank: assert property (p_bank) else $error("bank");
   property p_alu;
      alu_flags_we |=> {sw[7], sw[6], sw[2]} ==
         {$past(carry_in), $past(half_carry_in), $past(overflow_in)};
   endproperty
   a_alu: assert property (p_alu) else $error("alu flags");
   property p_user; !sfr_wr && !sfr_bit_wr |=> $stable(sw[5]) && $stable(sw[1]); endproperty
   a_user: assert property (p_user) else $error("user flags");
   property p_main; main_we |=> main_operand == $past(main_wdata); endproperty
   a_main: assert property (p_main) else $error("main load");
   property p_rd; sfr_addr == MAIN_ADDR |=> sfr_rdata == main_operand; endproperty
   a_rd: assert property (p_rd) else $error("main read");
   property p_rd_status; sfr_addr == STATUS_ADDR |=> sfr_rdata == program_status_word; endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read");
   property p_idle; irq_pending == '0 |=> !irq_take; endproperty
   a_idle: assert property (p_idle) else $error("take unasked");
   property p_src; irq_take |-> $onehot(irq_take_src & $past(irq_pending)); endproperty
   a_src: assert property (p_src) else $error("take source");
endmodule : status_regs_checker
bind status_regs status_regs_checker #(.IRQS(IRQS)) u_status_regs_checker (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr),
   .sfr_bit_wr(sfr_bit_wr),
   .sfr_rdata(sfr_rdata),
   .alu_flags_we(alu_flags_we),
   .carry_in(carry_in),
   .half_carry_in(half_carry_in),
   .overflow_in(overflow_in),
   .main_we(main_we),
   .main_wdata(main_wdata),
   .irq_pending(irq_pending),
   .irq_take(irq_take),
   .irq_take_src(irq_take_src),
   .program_status_word(program_status_word),
   .main_operand(main_operand),
   .bank_base_addr(bank_base_addr)
);

// ===== tb.sv
// Bench for status_regs: register access, flags, banks and interrupt gate.
// Assumes the checker binds itself onto the design.
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
   import status_regs_pkg::*;
   logic core_clk = 0, rst_n = 0, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, irq_take;
   logic alu_flags_we = 0, carry_in = 0, half_carry_in = 0, overflow_in = 0, irq_return = 0;
   logic main_we = 0, second_we = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, main_wdata = 0, second_wdata = 0, sfr_rdata;
   logic [7:0] irq_pending = 0, irq_priority_high = 0, irq_take_src, program_status_word;
   logic [7:0] main_operand, second_operand;
   logic [4:0] bank_base_addr;
   logic [2:0] sfr_bit_sel = 0;
   int mismatches = 0, tests_run = 0, cyc = 0;
   always #20 core_clk = ~core_clk;
   status_regs u_status_regs (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata),
      .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_sel(sfr_bit_sel),
      .sfr_bit_val(sfr_bit_val),
      .sfr_rdata(sfr_rdata),
      .alu_flags_we(alu_flags_we),
      .carry_in(carry_in),
      .half_carry_in(half_carry_in),
      .overflow_in(overflow_in),
      .main_we(main_we),
      .main_wdata(main_wdata),
      .second_we(second_we),
      .second_wdata(second_wdata),
      .irq_pending(irq_pending),
      .irq_priority_high(irq_priority_high),
      .irq_return(irq_return),
      .irq_take(irq_take),
      .irq_take_src(irq_take_src),
      .program_status_word(program_status_word),
      .main_operand(main_operand),
      .second_operand(second_operand),
      .bank_base_addr(bank_base_addr)
   );
   // A bit write carries its value in the low bit of d.
   task automatic wr(input logic [7:0] a, d, input logic bw, input logic [2:0] s);
      @(negedge core_clk);
      {sfr_addr, sfr_wdata, sfr_bit_sel, sfr_bit_val, sfr_wr, sfr_bit_wr} = {a, d, s, d[0], !bw, bw};
      @(negedge core_clk);
      {sfr_wr, sfr_bit_wr} = 2'b00;
   endtask : wr
   task automatic rd(input logic [7:0] a, e, input string n);
      @(negedge core_clk);
      sfr_addr = a;
      @(negedge core_clk);
      `CHK(n, e, sfr_rdata)
   endtask : rd
   task automatic reset_values();
      rd(STATUS_ADDR, REG_RESET, "status");
      rd(MAIN_ADDR, REG_RESET, "main");
      rd(SECOND_ADDR, REG_RESET, "second");
   endtask : reset_values
   task automatic reg_access();
      wr(MAIN_ADDR, 8'h07, 1'h0, 3'h0);
      rd(MAIN_ADDR, 8'h07, "main");
      wr(STATUS_ADDR, 8'h3A, 1'h0, 3'h0);
      rd(STATUS_ADDR, 8'h3B, "status");
      `CHK("bank3", 5'h18, bank_base_addr)
      wr(STATUS_ADDR, 8'h00, 1'h1, 3'h4);
      rd(STATUS_ADDR, 8'h2B, "bit write");
      `CHK("bank1", 5'h08, bank_base_addr)
      wr(MAIN_ADDR, 8'h01, 1'h1, 3'h4);
      rd(MAIN_ADDR, 8'h17, "main bit");
      rd(STATUS_ADDR, 8'h2A, "parity");
      wr(SECOND_ADDR, 8'h5A, 1'h0, 3'h0);
      rd(SECOND_ADDR, 8'h5A, "second");
      wr(SECOND_ADDR, 8'h01, 1'h1, 3'h7);
      rd(SECOND_ADDR, 8'hDA, "second bit");
      wr(8'hD1, 8'hFF, 1'h0, 3'h0);
      rd(8'hD1, 8'h00, "unmapped");
   endtask : reg_access
   task automatic alu_ops();
      @(negedge core_clk);
      {carry_in, half_carry_in, overflow_in, alu_flags_we} = 4'hF;
      {main_we, main_wdata, second_we, second_wdata} = {1'b1, 8'h00, 1'b1, 8'h81};
      @(negedge core_clk);
      {alu_flags_we, main_we, second_we} = 3'b000;
      `CHK("alu status", 8'hEE, program_status_word)
      `CHK("second load", 8'h81, second_operand)
      `CHK("main load", 8'h00, main_operand)
   endtask : alu_ops
   // Pending source 0 is low priority and must wait for both returns.
   task automatic irq_gate();
      @(negedge core_clk);
      irq_pending = 8'h04;
      @(negedge core_clk);
      irq_pending = 8'h01;
      `CHK("take", 9'h104, {irq_take, irq_take_src})
      @(negedge core_clk);
      `CHK("equal", 1'b0, irq_take)
      {irq_pending, irq_priority_high} = {8'h21, 8'h20};
      @(negedge core_clk);
      `CHK("preempt", 9'h120, {irq_take, irq_take_src})
      {irq_pending, irq_priority_high} = {8'h41, 8'h60};
      @(negedge core_clk);
      `CHK("equal high", 1'b0, irq_take)
      {irq_pending, irq_return} = {8'h01, 1'b1};
      repeat (2) @(negedge core_clk);
      `CHK("restored low", 1'b0, irq_take)
      irq_return = 0;
      @(negedge core_clk);
      `CHK("idle take", 9'h101, {irq_take, irq_take_src})
      irq_pending = 0;
   endtask : irq_gate
   task automatic complete_run();
      if (mismatches == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 400) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(negedge core_clk);
      rst_n = 1;
      reset_values();
      reg_access();
      alu_ops();
      irq_gate();
      complete_run();
   end
endmodule : tb
